/* verification/dtc_pin_model.sv */
module dtc_pin_model (
   input  wire logic         clk_i,
   input  wire logic         ev_tgl_i,
   input  wire logic [1:0]   cap_tgl_i,
   output logic              event_pin_o = 1'b0,
   output logic [1:0]        cap_pin_o = 2'h0
);
   timeunit 1ns;
   timeprecision 1ps;

   // ------------------------------------------------------------
   // Pin drivers
   // ------------------------------------------------------------
   logic [1:0] gap = 2'h0;

   // Requests inside the hold-off are dropped, so no pin moves faster than half the clock rate.
   always @(posedge clk_i) begin
      if (gap != 2'h0) begin
         gap <= gap - 2'h1;
      end else if (ev_tgl_i || cap_tgl_i != 2'h0) begin
         event_pin_o <= event_pin_o ^ ev_tgl_i;
         cap_pin_o   <= cap_pin_o ^ cap_tgl_i;
         gap         <= 2'h2;
      end
   end
endmodule // dtc_pin_model

/* verification/dual_timer_event_counter_bench.sv */
module dual_timer_event_counter_bench
   import dtc_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;

   // ------------------------------------------------------------
   // Signals and models
   // ------------------------------------------------------------
   logic              clk_i = 1'b0;
   logic              rstn_i = 1'b0;
   logic [ADDR_W-1:0] addr_i = 3'h0;
   logic [DATA_W-1:0] wdata_i = 8'h00;
   logic              wr_i = 1'b0;
   logic              rd_i = 1'b0;
   logic [DATA_W-1:0] rdata_o;
   logic              ev_tgl = 1'b0;
   logic [1:0]        cap_tgl = 2'h0;
   logic              event_input_pin_i;
   logic [1:0]        capture_input_pin_i;
   logic              first_compare_pin_o, second_compare_pin_o;
   logic              first_match_flag_o, second_match_flag_o;
   logic [1:0]        capture_irq_o;
   int                err_count = 0;
   int                cmp_count = 0;
   int                seed = 32'he779;
   int                irq_n [2] = '{0, 0};
   int                div0 [$] = '{2, 4, 8, 32, 128, 512, 2048};
   int                div1 [$] = '{1, 2, 8};

   dtc_dual_timer u_dtc_dual_timer (.clk_i, .rstn_i, .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o,
      .event_input_pin_i, .capture_input_pin_i, .first_compare_pin_o, .second_compare_pin_o,
      .first_match_flag_o, .second_match_flag_o, .capture_irq_o);
   dtc_pin_model u_dtc_pin_model (.clk_i(clk_i), .ev_tgl_i(ev_tgl), .cap_tgl_i(cap_tgl),
      .event_pin_o(event_input_pin_i), .cap_pin_o(capture_input_pin_i));

   initial begin
      forever #10 clk_i = ~clk_i;
   end

   // The request pulses are counted here, because they stand for one cycle only.
   always @(posedge clk_i) begin
      if (capture_irq_o[0] === 1'b1) irq_n[0] <= irq_n[0] + 1;
      if (capture_irq_o[1] === 1'b1) irq_n[1] <= irq_n[1] + 1;
   end

   // ------------------------------------------------------------
   // Tasks
   // ------------------------------------------------------------
   task automatic check(input logic [15:0] got, input logic [15:0] exp);
      cmp_count++;
      if (got !== exp) begin
         err_count++;
         $display("unexpected at %0t: got %h, expected %h", $time, got, exp);
      end
   endtask

   task automatic wr(input logic [2:0] a, input logic [7:0] d);
      @(posedge clk_i);
      addr_i <= a;
      wdata_i <= d;
      wr_i <= 1'b1;
      @(posedge clk_i);
      wr_i <= 1'b0;
   endtask

   task automatic rdchk(input logic [2:0] a, input logic [7:0] e);
      @(posedge clk_i);
      addr_i <= a;
      rd_i <= 1'b1;
      @(posedge clk_i);
      rd_i <= 1'b0;
      #1 check({8'h00, rdata_o}, {8'h00, e});
   endtask

   // Pins are spaced well apart so that each edge is seen and acted on before the next.
   task automatic tgl(input logic ev, input logic [1:0] cp);
      @(posedge clk_i);
      ev_tgl <= ev;
      cap_tgl <= cp;
      @(posedge clk_i);
      ev_tgl <= 1'b0;
      cap_tgl <= 2'h0;
      repeat (8) @(posedge clk_i);
   endtask

   task automatic events(input int n);
      repeat (n) begin
         tgl(1'b1, 2'h0);
         tgl(1'b1, 2'h0);
      end
   endtask

   // Only the span between two toggles counts, since the divider phase is free at a mode change.
   task automatic half(input bit sel, output int n);
      logic p;
      int   t;
      n = 0;
      t = 0;
      #1 p = sel ? second_compare_pin_o : first_compare_pin_o;
      while ((sel ? second_compare_pin_o : first_compare_pin_o) === p && t < 40000) begin
         @(posedge clk_i);
         #1 t++;
      end
      p = sel ? second_compare_pin_o : first_compare_pin_o;
      while ((sel ? second_compare_pin_o : first_compare_pin_o) === p && n < 40000) begin
         @(posedge clk_i);
         #1 n++;
      end
   endtask

   task automatic results;
      $display("comparisons %0d, mismatches %0d", cmp_count, err_count);
      if (err_count == 0 && cmp_count > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask

   // ------------------------------------------------------------
   // Scenarios
   // ------------------------------------------------------------
   initial begin
      logic [15:0] c16;
      int          n, k, c0, m;
      repeat (12) @(posedge clk_i);
      rstn_i <= 1'b1;
      rdchk(ADDR_MODE0, REG_RESET);
      rdchk(ADDR_FLAGS, 8'h00);
      c16 = 16'h0100 + 16'($random(seed) & 32'h3f);
      wr(ADDR_FUNC_A, 8'h04);
      wr(ADDR_TIMER0, c16[7:0]);
      wr(ADDR_TIMER1, c16[15:8]);
      wr(ADDR_MODE1, 8'hc3);
      wr(ADDR_MODE0, 8'h8f);
      events(int'(c16));
      rdchk(ADDR_TIMER0, c16[7:0]);
      rdchk(ADDR_TIMER1, c16[15:8]);
      rdchk(ADDR_FLAGS, 8'h00);
      events(1);
      rdchk(ADDR_FLAGS, 8'h01);
      check({14'h0000, second_match_flag_o, first_match_flag_o}, 16'h0001);
      rdchk(ADDR_TIMER1, 8'h00);
      wr(ADDR_MODE1, 8'h00);
      wr(ADDR_FLAGS, 8'h01);
      rdchk(ADDR_FLAGS, 8'h00);
      k = 2 + ($random(seed) & 7);
      wr(ADDR_TIMER0, 8'(k));
      events(k);
      rdchk(ADDR_TIMER0, 8'(k));
      events(1);
      rdchk(ADDR_TIMER0, 8'h00);
      rdchk(ADDR_FLAGS, 8'h01);
      wr(ADDR_FLAGS, 8'h01);
      wr(ADDR_MODE0, 8'haf);
      wr(ADDR_EDGE, {4'h0, EDGE_RISE, EDGE_RISE});
      wr(ADDR_TIMER0, 8'hff);
      k = 1 + ($random(seed) & 7);
      events(k);
      tgl(1'b0, 2'h1);
      rdchk(ADDR_TIMER0, 8'(k));
      wr(ADDR_TIMER0, 8'h02);
      events(3);
      rdchk(ADDR_FLAGS, 8'h01);
      wr(ADDR_MODE1, 8'h20);
      for (int e = 0; e < 4; e++) begin
         wr(ADDR_EDGE, 8'(e * 5));
         n = irq_n[0];
         m = irq_n[1];
         tgl(1'b0, 2'h3);
         tgl(1'b0, 2'h3);
         check(16'(irq_n[0] - n), (e == 3) ? 16'h0002 : 16'(e != 0));
         check(16'(irq_n[1] - m), (e == 3) ? 16'h0002 : 16'(e != 0));
      end
      rdchk(ADDR_TIMER0, 8'h00);
      wr(ADDR_FLAGS, 8'h03);
      c0 = 1 + ($random(seed) & 3);
      wr(ADDR_TIMER0, 8'(c0));
      foreach (div0[i]) begin
         wr(ADDR_MODE0, 8'h80 | 8'(i));
         half(1'b0, n);
         check(16'(n), 16'(div0[i] * (c0 + 1)));
      end
      wr(ADDR_MODE0, 8'h00);
      rdchk(ADDR_FLAGS, 8'h01);
      wr(ADDR_FLAGS, 8'h01);
      k = 1 + ($random(seed) & 15);
      wr(ADDR_FUNC_B, 8'h40);
      wr(ADDR_TIMER1, 8'(k));
      foreach (div1[i]) begin
         wr(ADDR_MODE1, 8'h80 | 8'(i));
         half(1'b1, n);
         check(16'(n), 16'(div1[i] * (k + 1)));
      end
      rdchk(ADDR_FLAGS, 8'h02);
      check({14'h0000, second_match_flag_o, first_match_flag_o}, 16'h0002);
      results;
   end

   initial begin
      #(60000 * 20);
      err_count++;
      results;
   end
endmodule // dual_timer_event_counter_bench

/* verilog/dtc_dual_timer.sv */
// Behaviour
// [R1] Two 8-bit timers, cascadable to 16 bits.
// [R2] Mode bits select timer, capture, compare modes.
// [R3] Prescale /2../2048 first, /1,/2,/8 second.
// [R4] Count from 00, wrap to 00 on match.
// [R5] Each timer match sets its own flag.
// [R6] Read gives count, write loads compare value.
// [R7] Only first timer counts external events.
// [R8] Software routes event pin via function bit.
// [R9] Clock code 111 counts event pin edges.
// [R10] Event rate at most half oscillator; code needs each pin level held two cycles, so a quarter at most.
// [R11] Software loads compare values 1..FF first.
// [R12] 16-bit match wraps, sets first flag only.
// [R13] Cascade needs second select 11, cascade bit.
// [R14] Match toggles compare pin, 50:50 square wave.
// [R15] Second pin needs function bit, no pulse.
// [R16] Capture enabled per timer by mode bit.
// [R17] Capture mode still counts and flags matches.
// [R18] Capture edge stores count, clears counter.
// [R19] Capture mode reads return captured value.
// [R20] Capture edge falling, rising or both.
// [R21] Capture edge raises external request.
// [R22] Pins synchronised, edges detected on clock.
//
// Added by the designer: the strobed register port and the register offsets.
module dtc_dual_timer
   import dtc_pkg::*;
#(
   parameter int DIV_BITS = PRESCALE_BITS
) (
   input  wire logic                clk_i,
   input  wire logic                rstn_i,
   input  wire logic [ADDR_W-1:0]   addr_i,
   input  wire logic [DATA_W-1:0]   wdata_i,
   input  wire logic                wr_i,
   input  wire logic                rd_i,
   output logic      [DATA_W-1:0]   rdata_o,
   input  wire logic                event_input_pin_i,
   input  wire logic [1:0]          capture_input_pin_i,
   output logic                     first_compare_pin_o,
   output logic                     second_compare_pin_o,
   output logic                     first_match_flag_o,
   output logic                     second_match_flag_o,
   output logic      [1:0]          capture_irq_o
);

   if (DIV_BITS < PRESCALE_BITS) begin : g_chk
      $error("Prescaler too short for the largest divide ratio.");
   end

   // ------------------------------------------------------------
   // Registers
   // ------------------------------------------------------------
   logic [DATA_W-1:0] first_timer_mode_reg;
   logic [DATA_W-1:0] second_timer_mode_reg;
   logic [DATA_W-1:0] first_compare_value;
   logic [DATA_W-1:0] second_compare_value;
   logic [DATA_W-1:0] first_count_reg;
   logic [DATA_W-1:0] second_count_reg;
   logic [DATA_W-1:0] first_capture_value;
   logic [DATA_W-1:0] second_capture_value;
   logic [DATA_W-1:0] edge_select_reg;
   logic [DATA_W-1:0] port_a_function_select;
   logic [DATA_W-1:0] port_b_function_select;
   logic              first_match_flag;
   logic              second_match_flag;
   logic              first_compare_pin;
   logic              second_compare_pin;
   logic [1:0]        capture_irq;
   logic [DATA_W-1:0] rdata;

   logic [DATA_W-1:0] next_count0;
   logic [DATA_W-1:0] next_count1;
   logic [DATA_W-1:0] read_mux;

   // ------------------------------------------------------------
   // Prescaler and pin synchronisers
   // ------------------------------------------------------------
   logic [DIV_BITS:0] tap;
   logic [2:0]        pin_rise;
   logic [2:0]        pin_fall;

   dtc_prescaler #(
      .DIV_BITS (DIV_BITS)
   ) u_prescaler (
      .clk_i    (clk_i),
      .rstn_i   (rstn_i),
      .tap_o    (tap)
   );

   dtc_pin_sync #(
      .PINS     (3)
   ) u_pin_sync (
      .clk_i    (clk_i),
      .rstn_i   (rstn_i),
      .pin_i    ({capture_input_pin_i, event_input_pin_i}), // R22
      .rise_o   (pin_rise),
      .fall_o   (pin_fall)
   );

   // ------------------------------------------------------------
   // Decode
   // ------------------------------------------------------------
   wire wr_mode0  = wr_i && (addr_i == ADDR_MODE0);
   wire wr_mode1  = wr_i && (addr_i == ADDR_MODE1);
   wire wr_timer0 = wr_i && (addr_i == ADDR_TIMER0);
   wire wr_timer1 = wr_i && (addr_i == ADDR_TIMER1);
   wire wr_flags  = wr_i && (addr_i == ADDR_FLAGS);
   wire wr_edge   = wr_i && (addr_i == ADDR_EDGE);
   wire wr_func_a = wr_i && (addr_i == ADDR_FUNC_A);
   wire wr_func_b = wr_i && (addr_i == ADDR_FUNC_B);

   wire [2:0] clk0_sel = first_timer_mode_reg[MODE0_CLK_LSB +: 3];
   wire [1:0] clk1_sel = second_timer_mode_reg[MODE1_CLK_LSB +: 2];
   wire       run0     = first_timer_mode_reg[MODE_RUN_BIT];
   wire       run1     = second_timer_mode_reg[MODE_RUN_BIT];
   wire       cap_en0  = first_timer_mode_reg[MODE0_CAP_BIT]; // R16
   wire       cap_en1  = second_timer_mode_reg[MODE1_CAP_BIT]; // R16
   wire       pulse_en = second_timer_mode_reg[MODE1_PULSE_BIT];

   // The pair only joins when both the cascade bit and select 11 are set.
   wire cascade = second_timer_mode_reg[MODE1_CASC_BIT] && (clk1_sel == CLK1_CASCADE); // R1 R13

   // ------------------------------------------------------------
   // Count clocks
   // ------------------------------------------------------------
   wire event_mode = (clk0_sel == CLK0_EVENT); // R9
   wire event_rise = first_timer_mode_reg[MODE0_RISE_BIT];
   wire event_route = port_a_function_select[FUNC_A_EVENT]; // R8
   wire event_edge = event_route && (event_rise ? pin_rise[0] : pin_fall[0]); // R9 R10

   // Index is forced in range so the event code never reads past the table.
   wire [2:0] tap0_idx  = event_mode ? 3'h0 : clk0_sel;
   wire       presc0    = tap[T0_TAP[tap0_idx]]; // R3
   wire [1:0] tap1_idx  = (clk1_sel == CLK1_CASCADE) ? 2'h0 : clk1_sel;
   wire       presc1    = (clk1_sel != CLK1_CASCADE) && tap[T1_TAP[tap1_idx]]; // R3 R7

   wire tick0 = run0 && (event_mode ? event_edge : presc0); // R9
   wire tick1 = run1 && !cascade && presc1; // R7

   // ------------------------------------------------------------
   // Capture edges
   // ------------------------------------------------------------
   wire [1:0] edge_sel0 = edge_select_reg[EDGE0_LSB +: 2];
   wire [1:0] edge_sel1 = edge_select_reg[EDGE1_LSB +: 2];

   wire cap_edge0 = ((edge_sel0 == EDGE_FALL) && pin_fall[1])
                 || ((edge_sel0 == EDGE_RISE) && pin_rise[1])
                 || ((edge_sel0 == EDGE_BOTH) && (pin_rise[1] || pin_fall[1])); // R20
   wire cap_edge1 = ((edge_sel1 == EDGE_FALL) && pin_fall[2])
                 || ((edge_sel1 == EDGE_RISE) && pin_rise[2])
                 || ((edge_sel1 == EDGE_BOTH) && (pin_rise[2] || pin_fall[2])); // R20

   wire cap_hit0 = cap_en0 && cap_edge0; // R18
   wire cap_hit1 = !cascade && cap_en1 && cap_edge1; // R18

   // ------------------------------------------------------------
   // Match detection
   // ------------------------------------------------------------
   wire match0  = (first_count_reg == first_compare_value);
   wire match1  = (second_count_reg == second_compare_value);
   wire match16 = ({second_count_reg, first_count_reg}
               == {second_compare_value, first_compare_value});

   // Matches still flag in capture mode so long pulses can be measured.
   wire ev0 = tick0 && (cascade ? match16 : match0); // R5 R12 R17
   wire ev1 = tick1 && match1; // R5 R17

   wire cmp1_en = port_b_function_select[FUNC_B_COMPARE] && !pulse_en; // R15
   wire cmp1_ev = cascade ? ev0 : ev1;

   // ------------------------------------------------------------
   // Next count
   // ------------------------------------------------------------
   // A capture edge wins over a clock tick in the same cycle.
   always_comb begin
      next_count0 = first_count_reg;
      next_count1 = second_count_reg;
      if (cascade) begin
         if (cap_hit0) begin
            next_count0 = '0; // R18
            next_count1 = '0;
         end else if (tick0 && match16) begin
            next_count0 = '0; // R12
            next_count1 = '0;
         end else if (tick0) begin
            {next_count1, next_count0} = 16'({second_count_reg, first_count_reg} + 16'h0001); // R12
         end
      end else begin
         if (cap_hit0) begin
            next_count0 = '0; // R18
         end else if (tick0) begin
            next_count0 = match0 ? '0 : 8'(first_count_reg + 8'h01); // R4
         end
         if (cap_hit1) begin
            next_count1 = '0; // R18
         end else if (tick1) begin
            next_count1 = match1 ? '0 : 8'(second_count_reg + 8'h01); // R4
         end
      end
   end

   // ------------------------------------------------------------
   // Read mux
   // ------------------------------------------------------------
   wire rd_first_capture_enable = cap_en0; // R19
   wire rd_second_capture_enable = cap_en1 || (cascade && cap_en0); // R19

   always_comb begin
      case (addr_i)
         ADDR_MODE0:  read_mux = first_timer_mode_reg;
         ADDR_MODE1:  read_mux = second_timer_mode_reg;
         ADDR_TIMER0: read_mux = rd_first_capture_enable ? first_capture_value : first_count_reg; // R6 R19
         ADDR_TIMER1: read_mux = rd_second_capture_enable ? second_capture_value : second_count_reg; // R6 R19
         ADDR_FLAGS:  read_mux = {6'h00, second_match_flag, first_match_flag};
         ADDR_EDGE:   read_mux = edge_select_reg;
         ADDR_FUNC_A: read_mux = port_a_function_select;
         ADDR_FUNC_B: read_mux = port_b_function_select;
         default:     read_mux = '0;
      endcase
   end

   // ------------------------------------------------------------
   // Software registers
   // ------------------------------------------------------------
   // Compare values are undefined after reset; a known value keeps sims clean.
   always_ff @(posedge clk_i) begin
      if (!rstn_i) begin
         first_timer_mode_reg   <= REG_RESET;
         second_timer_mode_reg  <= REG_RESET;
         edge_select_reg        <= REG_RESET;
         port_a_function_select <= REG_RESET;
         port_b_function_select <= REG_RESET;
         first_compare_value    <= DATA_RESET;
         second_compare_value   <= DATA_RESET;
      end else begin
         if (wr_mode0)  first_timer_mode_reg   <= wdata_i; // R2
         if (wr_mode1)  second_timer_mode_reg  <= wdata_i; // R2
         if (wr_edge)   edge_select_reg        <= wdata_i;
         if (wr_func_a) port_a_function_select <= wdata_i;
         if (wr_func_b) port_b_function_select <= wdata_i;
         if (wr_timer0) first_compare_value    <= wdata_i; // R6 R11
         if (wr_timer1) second_compare_value   <= wdata_i; // R6 R11
      end
   end

   // ------------------------------------------------------------
   // Counters, captures and flags
   // ------------------------------------------------------------
   always_ff @(posedge clk_i) begin
      if (!rstn_i) begin
         first_count_reg      <= '0;
         second_count_reg     <= '0;
         first_capture_value  <= '0;
         second_capture_value <= '0;
      end else begin
         first_count_reg  <= next_count0;
         second_count_reg <= next_count1;
         if (cap_hit0 && cascade) begin
            {second_capture_value, first_capture_value} <= {second_count_reg, first_count_reg}; // R18
         end else if (cap_hit0) begin
            first_capture_value <= first_count_reg; // R18
         end
         if (cap_hit1) second_capture_value <= second_count_reg; // R18
      end
   end

   // Setting wins over a write-one clear in the same cycle.
   always_ff @(posedge clk_i) begin
      if (!rstn_i) begin
         first_match_flag  <= 1'b0;
         second_match_flag <= 1'b0;
      end else begin
         first_match_flag  <= ev0 || (first_match_flag && !(wr_flags && wdata_i[FLAG0_BIT])); // R5
         second_match_flag <= ev1 || (second_match_flag && !(wr_flags && wdata_i[FLAG1_BIT])); // R5
      end
   end

   // ------------------------------------------------------------
   // Pins and read data
   // ------------------------------------------------------------
   always_ff @(posedge clk_i) begin
      if (!rstn_i) begin
         first_compare_pin  <= 1'b0;
         second_compare_pin <= 1'b0;
         capture_irq        <= 2'h0;
         rdata              <= '0;
      end else begin
         if (ev0) first_compare_pin <= !first_compare_pin; // R14
         if (cmp1_en && cmp1_ev) second_compare_pin <= !second_compare_pin; // R14 R15
         capture_irq <= {cap_edge1, cap_edge0}; // R21
         rdata       <= rd_i ? read_mux : '0;
      end
   end

   assign rdata_o              = rdata;
   assign first_compare_pin_o  = first_compare_pin;
   assign second_compare_pin_o = second_compare_pin;
   assign first_match_flag_o   = first_match_flag;
   assign second_match_flag_o  = second_match_flag;
   assign capture_irq_o        = capture_irq;

   // ------------------------------------------------------------
   // Assertions
   // ------------------------------------------------------------
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!rstn_i);

   AST_READ_COUNT: assert property ( // R6
      rd_i && addr_i == ADDR_TIMER0 && !cap_en0 |=> rdata_o == $past(first_count_reg))
      else $error("Timer read did not return the count.");

   AST_READ_CAPTURE: assert property ( // R19
      rd_i && addr_i == ADDR_TIMER0 && cap_en0 |=> rdata_o == $past(first_capture_value))
      else $error("Capture mode read did not return the capture.");

   AST_WRITE_COMPARE: assert property ( // R6
      wr_timer1 |=> second_compare_value == $past(wdata_i))
      else $error("Timer write did not load the compare value.");

   AST_WRAP: assert property ( // R4
      !cascade && tick0 && match0 && !cap_hit0 |=> first_count_reg == 8'h00)
      else $error("Counter did not wrap on match.");

   AST_COUNT_UP: assert property ( // R4
      !cascade && tick0 && !match0 && !cap_hit0 |=> first_count_reg == 8'($past(first_count_reg) + 8'h01))
      else $error("Counter did not advance on tick.");

   AST_FLAG_SET: assert property ( // R5
      ev1 |=> second_match_flag_o)
      else $error("Match did not set the flag.");

   AST_CASCADE_FLAG: assert property ( // R12
      cascade && !second_match_flag |=> !second_match_flag)
      else $error("Second flag set in cascade mode.");

   AST_CAPTURE: assert property ( // R18
      !cascade && cap_hit0 |=> first_count_reg == 8'h00 && first_capture_value == $past(first_count_reg))
      else $error("Capture did not store and clear.");

   AST_CAPTURE_IRQ: assert property ( // R21
      cap_edge1 |=> capture_irq_o[1] ##1 !capture_irq_o[1] || $past(cap_edge1))
      else $error("Capture request not raised.");

   AST_NO_EVENT_T1: assert property ( // R7
      !cascade && !tick1 && !cap_hit1 |=> $stable(second_count_reg))
      else $error("Second counter moved without its clock.");

   AST_TOGGLE: assert property ( // R14
      ev0 |=> first_compare_pin_o != $past(first_compare_pin_o))
      else $error("Compare pin did not toggle on match.");

   AST_DIV2: assert property ( // R3
      run0 && clk0_sel == 3'h0 && tick0 && !wr_mode0 |=> !tick0)
      else $error("Divide by two ticked twice in a row.");

   COV_CASCADE_MATCH: cover property (cascade && ev0);
   COV_CAPTURE1: cover property (cap_hit1);
   COV_EVENT_TICK: cover property (event_mode && tick0);

endmodule // dtc_dual_timer

/* verilog/dtc_pin_sync.sv */
module dtc_pin_sync
   import dtc_pkg::*;
#(
   parameter int PINS = SYNC_PINS
) (
   input  wire logic              clk_i,
   input  wire logic              rstn_i,
   input  wire logic [PINS-1:0]   pin_i,
   output logic      [PINS-1:0]   rise_o,
   output logic      [PINS-1:0]   fall_o
);

   if (PINS < 1) begin : g_chk
      $error("At least one pin is needed.");
   end

   // ------------------------------------------------------------
   // Three stage synchroniser per pin
   // ------------------------------------------------------------
   for (genvar p = 0; p < PINS; p++) begin : g_pin
      logic s1;
      logic s2;
      logic s3;
      logic level;

      // A change counts only once the second and third stages agree, so a one-cycle glitch is ignored.
      wire agree = (s2 == s3);

      always_ff @(posedge clk_i) begin
         if (!rstn_i) begin
            s1    <= 1'b0;
            s2    <= 1'b0;
            s3    <= 1'b0;
            level <= 1'b0;
         end else begin
            s1 <= pin_i[p];
            s2 <= s1;
            s3 <= s2;
            if (agree) level <= s3;
         end
      end

      assign rise_o[p] = agree & s3 & ~level;
      assign fall_o[p] = agree & ~s3 & level;
   end

endmodule // dtc_pin_sync

/* verilog/dtc_pkg.sv */
package dtc_pkg;

   // ------------------------------------------------------------
   // Bus and data widths
   // ------------------------------------------------------------
   localparam int DATA_W        = 8;
   localparam int ADDR_W        = 3;
   localparam int PRESCALE_BITS = 11;
   localparam int SYNC_PINS     = 3;

   // ------------------------------------------------------------
   // Register offsets
   // ------------------------------------------------------------
   localparam logic [ADDR_W-1:0] ADDR_MODE0  = 3'h0;
   localparam logic [ADDR_W-1:0] ADDR_MODE1  = 3'h1;
   localparam logic [ADDR_W-1:0] ADDR_TIMER0 = 3'h2;
   localparam logic [ADDR_W-1:0] ADDR_TIMER1 = 3'h3;
   localparam logic [ADDR_W-1:0] ADDR_FLAGS  = 3'h4;
   localparam logic [ADDR_W-1:0] ADDR_EDGE   = 3'h5;
   localparam logic [ADDR_W-1:0] ADDR_FUNC_A = 3'h6;
   localparam logic [ADDR_W-1:0] ADDR_FUNC_B = 3'h7;

   // ------------------------------------------------------------
   // Field positions
   // ------------------------------------------------------------
   localparam int MODE0_CLK_LSB   = 0;
   localparam int MODE0_RISE_BIT  = 3;
   localparam int MODE0_CAP_BIT   = 5;
   localparam int MODE1_CLK_LSB   = 0;
   localparam int MODE1_PULSE_BIT = 4;
   localparam int MODE1_CAP_BIT   = 5;
   localparam int MODE1_CASC_BIT  = 6;
   localparam int MODE_RUN_BIT    = 7;
   localparam int FLAG0_BIT       = 0;
   localparam int FLAG1_BIT       = 1;
   localparam int EDGE0_LSB       = 0;
   localparam int EDGE1_LSB       = 2;
   localparam int FUNC_A_EVENT    = 2;
   localparam int FUNC_B_COMPARE  = 6;

   // ------------------------------------------------------------
   // Encodings and reset values
   // ------------------------------------------------------------
   localparam logic [2:0] CLK0_EVENT   = 3'h7;
   localparam logic [1:0] CLK1_CASCADE = 2'h3;
   localparam logic [1:0] EDGE_FALL    = 2'h1;
   localparam logic [1:0] EDGE_RISE    = 2'h2;
   localparam logic [1:0] EDGE_BOTH    = 2'h3;
   localparam logic [7:0] REG_RESET    = 8'h00;
   localparam logic [7:0] DATA_RESET   = 8'hff;

   // Prescaler tap per clock select code: tap k divides by 2**k.
   localparam int T0_TAP [7] = '{1, 2, 3, 5, 7, 9, 11};
   localparam int T1_TAP [3] = '{0, 1, 3};

endpackage : dtc_pkg

/* verilog/dtc_prescaler.sv */
module dtc_prescaler
   import dtc_pkg::*;
#(
   parameter int DIV_BITS = PRESCALE_BITS
) (
   input  wire logic                clk_i,
   input  wire logic                rstn_i,
   output logic      [DIV_BITS:0]   tap_o
);

   // ------------------------------------------------------------
   // Free running divider
   // ------------------------------------------------------------
   logic [DIV_BITS-1:0] div_cnt;

   if (DIV_BITS < PRESCALE_BITS) begin : g_chk
      $error("Prescaler too short for the largest divide ratio.");
   end

   always_ff @(posedge clk_i) begin
      if (!rstn_i) begin
         div_cnt <= '0;
      end else begin
         div_cnt <= div_cnt + 1'b1;
      end
   end

   // Tap 0 fires every cycle; tap k fires once every 2**k cycles.
   assign tap_o[0] = 1'b1;

   for (genvar k = 1; k <= DIV_BITS; k++) begin : g_tap
      assign tap_o[k] = &div_cnt[k-1:0];
   end

endmodule // dtc_prescaler
